// ---- core/gpe_gpio_port.sv ----
// gpio ports with input readback, direction, pullup, edge interrupts and clock select
//
// Chosen here: the AXI4-Lite register port.

// Operation
// - port input registers are read-only and return current pin levels; no fixed reset.
// - port 3 input returns pins on bits 8:0; bits 15:9 read zero.
// - for an input pin, output bit 1 enables weak pullup, 0 leaves tri-state.
// - each of eight interrupt lines has an edge bit: 0 rising, 1 falling.
// - edge-select register clears to 00h on every reset; freely read/write.
// - clock-source control clears to 00h only on power-on reset; kept otherwise.
// - clock-control bit 0 takes base system clock from pin P2.4, overriding crystal-1.
// - clock-control bit 1 takes base front-end clock from pin P2.6, overriding crystal-2.
// - clock-control bits 7:2 are reserved and read zero.
// - direction 1 drives pin from output bit; 0 makes it an input.
// - port 0..2 direction registers clear to 00h on every reset; freely read/write.
// - interrupt flag sets on selected edge, requests if enabled, stays until cleared.
// - port 1 and 2 outputs reset to FFh; direction changes leave them unchanged.
module gpe_gpio_port
  import gpe_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic porRst,
  input wire gpe_axil_req_t axiReq,
  output gpe_axil_rsp_t axiRsp,
  input wire logic [7:0] port0In,
  input wire logic [7:0] port1In,
  input wire logic [7:0] port2In,
  input wire logic [8:0] port3In,
  output gpe_port_drive_t port0Drive,
  output gpe_port_drive_t port1Drive,
  output gpe_port_drive_t port2Drive,
  output logic sysClkFromPin,
  output logic afeClkFromPin,
  output logic irq
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0] p0Sync1;
    logic [7:0] p0Sync2;
    logic [7:0] p0Prev;
    logic [7:0] p1Sync1;
    logic [7:0] p1Sync2;
    logic [7:0] p2Sync1;
    logic [7:0] p2Sync2;
    logic [8:0] p3Sync1;
    logic [8:0] p3Sync2;
    logic [7:0] out0;
    logic [7:0] out1;
    logic [7:0] out2;
    logic [7:0] dir0;
    logic [7:0] dir1;
    logic [7:0] dir2;
    logic [7:0] edgeSel;
    logic [1:0] clkCtrl;
    logic [7:0] status;
    logic [7:0] mask;
    logic awHeld;
    logic wHeld;
    logic [7:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    gpe_axil_rsp_t rsp;
    gpe_port_drive_t drv0;
    gpe_port_drive_t drv1;
    gpe_port_drive_t drv2;
    logic sysSel;
    logic afeSel;
    logic irq;
  } gpe_state_t;

  gpe_state_t s;
  gpe_state_t next_s;

  // ==========================================================================
  // helpers
  function automatic gpe_port_drive_t drive(input logic [7:0] out, input logic [7:0] dir);
    gpe_port_drive_t d;
    d.out = out;
    d.oeN = ~dir;
    d.pullupEn = ~dir & out;
    return d;
  endfunction

  function automatic logic [31:0] read_reg(input gpe_state_t st, input logic [7:0] addr,
                                           output logic ok);
    logic [31:0] v;
    v = 32'h0000_0000;
    ok = 1'b1;
    if (addr == gpe_byte_addr(IDX_PORT0_OUT)) begin
      v[7:0] = st.out0;
    end else if (addr == gpe_byte_addr(IDX_PORT1_OUT)) begin
      v[7:0] = st.out1;
    end else if (addr == gpe_byte_addr(IDX_PORT2_OUT)) begin
      v[7:0] = st.out2;
    end else if (addr == gpe_byte_addr(IDX_IRQ_STATUS)) begin
      v[7:0] = st.status;
    end else if (addr == gpe_byte_addr(IDX_IRQ_MASK)) begin
      v[7:0] = st.mask;
    end else if (addr == gpe_byte_addr(IDX_PORT1_IN)) begin
      v[7:0] = st.p1Sync2;
    end else if (addr == gpe_byte_addr(IDX_PORT2_IN)) begin
      v[7:0] = st.p2Sync2;
    end else if (addr == gpe_byte_addr(IDX_PORT3_IN)) begin
      v[8:0] = st.p3Sync2;
    end else if (addr == gpe_byte_addr(IDX_EDGE_SEL)) begin
      v[7:0] = st.edgeSel;
    end else if (addr == gpe_byte_addr(IDX_CLK_CTRL)) begin
      v[1:0] = st.clkCtrl;
    end else if (addr == gpe_byte_addr(IDX_PORT0_DIR)) begin
      v[7:0] = st.dir0;
    end else if (addr == gpe_byte_addr(IDX_PORT1_DIR)) begin
      v[7:0] = st.dir1;
    end else if (addr == gpe_byte_addr(IDX_PORT2_DIR)) begin
      v[7:0] = st.dir2;
    end else begin
      ok = 1'b0;
    end
    return v;
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] edgeHit;
    logic [7:0] clr;
    logic [7:0] wb;
    logic rdOk;
    logic wrOk;
    logic [31:0] rdVal;
    rise = 8'h00;
    fall = 8'h00;
    edgeHit = 8'h00;
    clr = 8'h00;
    wb = 8'h00;
    rdOk = 1'b0;
    wrOk = 1'b0;
    rdVal = 32'h0000_0000;
    next_s = s;

    // pins are asynchronous to clk
    next_s.p0Sync1 = port0In;
    next_s.p0Sync2 = s.p0Sync1;
    next_s.p0Prev = s.p0Sync2;
    next_s.p1Sync1 = port1In;
    next_s.p1Sync2 = s.p1Sync1;
    next_s.p2Sync1 = port2In;
    next_s.p2Sync2 = s.p2Sync1;
    next_s.p3Sync1 = port3In;
    next_s.p3Sync2 = s.p3Sync1;

    // port 0 pins double as the eight external interrupt lines
    rise = s.p0Sync2 & ~s.p0Prev;
    fall = ~s.p0Sync2 & s.p0Prev;
    edgeHit = (s.edgeSel & fall) | (~s.edgeSel & rise);

    // write channel: address and data may come in either order
    if (axiReq.awvalid && s.rsp.awready) begin
      next_s.awHeld = 1'b1;
      next_s.wAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && s.rsp.wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = axiReq.wdata;
      next_s.wStrb = axiReq.wstrb;
    end
    if (s.awHeld && s.wHeld && !s.rsp.bvalid) begin
      wb = s.wStrb[0] ? s.wData[7:0] : 8'h00;
      wrOk = 1'b1;
      if (s.wStrb[0]) begin
        if (s.wAddr == gpe_byte_addr(IDX_PORT0_OUT)) begin
          next_s.out0 = wb;
        end else if (s.wAddr == gpe_byte_addr(IDX_PORT1_OUT)) begin
          next_s.out1 = wb;
        end else if (s.wAddr == gpe_byte_addr(IDX_PORT2_OUT)) begin
          next_s.out2 = wb;
        end else if (s.wAddr == gpe_byte_addr(IDX_IRQ_STATUS)) begin
          clr = wb;
        end else if (s.wAddr == gpe_byte_addr(IDX_IRQ_MASK)) begin
          next_s.mask = wb;
        end else if (s.wAddr == gpe_byte_addr(IDX_EDGE_SEL)) begin
          next_s.edgeSel = wb;
        end else if (s.wAddr == gpe_byte_addr(IDX_CLK_CTRL)) begin
          next_s.clkCtrl = wb[1:0];
        end else if (s.wAddr == gpe_byte_addr(IDX_PORT0_DIR)) begin
          next_s.dir0 = wb;
        end else if (s.wAddr == gpe_byte_addr(IDX_PORT1_DIR)) begin
          next_s.dir1 = wb;
        end else if (s.wAddr == gpe_byte_addr(IDX_PORT2_DIR)) begin
          next_s.dir2 = wb;
        end
      end
      // input registers are read-only: writes there answer okay and do nothing
      rdVal = read_reg(s, s.wAddr, wrOk);
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rsp.bvalid && axiReq.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end

    // set wins over a clear in the same cycle
    next_s.status = (s.status & ~clr) | edgeHit;

    // read channel
    if (axiReq.arvalid && s.rsp.arready) begin
      rdVal = read_reg(s, axiReq.araddr, rdOk);
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = rdVal;
      next_s.rsp.rresp = rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rsp.rvalid && axiReq.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end

    // reset keeps the synchronisers running so readback follows the pins
    if (srst || porRst) begin
      next_s.out0 = OUT_RST;
      next_s.out1 = OUT_RST;
      next_s.out2 = OUT_RST;
      next_s.dir0 = DIR_RST;
      next_s.dir1 = DIR_RST;
      next_s.dir2 = DIR_RST;
      next_s.edgeSel = EDGE_SEL_RST;
      next_s.status = IRQ_STATUS_RST;
      next_s.mask = IRQ_MASK_RST;
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.wAddr = 8'h00;
      next_s.wData = 32'h0000_0000;
      next_s.wStrb = 4'h0;
      next_s.rsp = '0;
      if (porRst) begin
        next_s.clkCtrl = CLK_CTRL_RST;
      end
    end

    next_s.rsp.awready = !next_s.awHeld && !next_s.rsp.bvalid;
    next_s.rsp.wready = !next_s.wHeld && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;

    // pad controls are registered; direction leaves stored output data alone
    next_s.drv0 = drive(next_s.out0, next_s.dir0);
    next_s.drv1 = drive(next_s.out1, next_s.dir1);
    next_s.drv2 = drive(next_s.out2, next_s.dir2);
    // only the select is made here; the glitch-free clock mux sits in the clock unit
    next_s.sysSel = next_s.clkCtrl[SYSCLK_FROM_PIN_SEL_BIT];
    next_s.afeSel = next_s.clkCtrl[AFECLK_FROM_PIN_SEL_BIT];
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  // ==========================================================================
  // outputs
  assign axiRsp = s.rsp;
  assign port0Drive = s.drv0;
  assign port1Drive = s.drv1;
  assign port2Drive = s.drv2;
  assign sysClkFromPin = s.sysSel;
  assign afeClkFromPin = s.afeSel;
  assign irq = s.irq;

endmodule

// ---- dv/gpe_gpio_port_sva.sv ----
// concurrent checks on the ports of the gpio block
module gpe_gpio_port_sva
  import gpe_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic porRst,
  input wire gpe_axil_req_t axiReq,
  input wire gpe_axil_rsp_t axiRsp,
  input wire logic [7:0] port0In,
  input wire gpe_port_drive_t port1Drive,
  input wire logic sysClkFromPin,
  input wire logic afeClkFromPin,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst || porRst);
  // ====================
  // assertions
  pullup_tracks_out_a: assert property (
    (port1Drive.pullupEn & port1Drive.oeN) == (port1Drive.out & port1Drive.oeN))
    else $error("pullup differs from output bit on an input pin");
  reset_pads_a: assert property (disable iff (1'b0)
    srst |=> port1Drive.oeN == 8'hff && port1Drive.out == 8'hff && !irq)
    else $error("pads not at reset state");
  clk_sel_kept_a: assert property (disable iff (porRst)
    srst |=> sysClkFromPin == $past(sysClkFromPin) && afeClkFromPin == $past(afeClkFromPin))
    else $error("clock select lost on ordinary reset");
  por_clears_sel_a: assert property (disable iff (1'b0)
    porRst |=> !sysClkFromPin && !afeClkFromPin)
    else $error("clock select not cleared by power-on reset");
  read_answer_a: assert property (
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read data late");
  write_answer_a: assert property (
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |-> ##2 axiRsp.bvalid)
    else $error("write response late");
  upper_bits_zero_a: assert property (
    axiRsp.rvalid |-> axiRsp.rdata[31:9] == 23'h0)
    else $error("reserved read bits set");
  edge_synced_a: assert property ($rose(irq) |-> axiRsp.bvalid ||
    $past(port0In, 3) != $past(port0In, 4) || $past(port0In, 2) != $past(port0In, 3))
    else $error("interrupt without synchronised edge");
endmodule
bind gpe_gpio_port gpe_gpio_port_sva chk (.clk(clk), .srst(srst), .porRst(porRst),
  .axiReq(axiReq), .axiRsp(axiRsp), .port0In(port0In), .port1Drive(port1Drive),
  .sysClkFromPin(sysClkFromPin), .afeClkFromPin(afeClkFromPin), .irq(irq));

// ---- dv/gpe_pin_model.sv ----
// external pin model for one 8-bit port of the gpio block
module gpe_pin_model
  import gpe_pkg::*;
(
  input wire logic clk,
  input wire gpe_port_drive_t drv,
  input wire logic [7:0] ext,
  input wire logic [7:0] extEn,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drift = 8'h00;
  // ====================
  // pin resolution
  // an unheld, unpulled pin wanders so a floating read never looks stable
  always @(posedge clk) drift <= ~drift;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!drv.oeN[b]) pin[b] = drv.out[b];
      else if (extEn[b]) pin[b] = ext[b];
      else if (drv.pullupEn[b]) pin[b] = 1'b1;
      else pin[b] = drift[b];
    end
  end
endmodule

// ---- dv/tb_gpio_port_edge_clock_select.sv ----
// self-checking bench for the gpio block
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_gpio_port_edge_clock_select
  import gpe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic porRst = 1'b1;
  gpe_axil_req_t req = '0;
  gpe_axil_rsp_t rsp;
  gpe_port_drive_t drv [3];
  logic [7:0] ext [3] = '{default: 8'h00};
  logic [7:0] extEn [3] = '{default: 8'hff};
  logic [7:0] pin [3];
  logic [8:0] port3In = 9'h000;
  logic sysSel, afeSel, irq;
  int miscompares = 0;
  int numChecks = 0;
  always #10 clk = ~clk;
  gpe_gpio_port dut (.clk(clk), .srst(srst), .porRst(porRst), .axiReq(req), .axiRsp(rsp),
    .port0In(pin[0]), .port1In(pin[1]), .port2In(pin[2]), .port3In(port3In),
    .port0Drive(drv[0]), .port1Drive(drv[1]), .port2Drive(drv[2]),
    .sysClkFromPin(sysSel), .afeClkFromPin(afeSel), .irq(irq));
  for (genvar p = 0; p < 3; p++) begin : g_pins
    gpe_pin_model pm (.clk(clk), .drv(drv[p]), .ext(ext[p]), .extEn(extEn[p]), .pin(pin[p]));
  end
  // ====================
  // bus tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // every bus wait is bounded; a hung slave ends the run as a failure
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 100) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] r = RESP_OKAY);
    int n;
    bit a, w;
    n = 0;
    a = 0;
    w = 0;
    req.awaddr <= {idx, 2'b00};
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(a && w)) begin
      tick(n);
      a |= rsp.awready;
      w |= rsp.wready;
      req.awvalid <= !a;
      req.wvalid <= !w;
    end
    req.bready <= 1'b1;
    do tick(n); while (!rsp.bvalid);
    req.bready <= 1'b0;
    `CHK("bresp", r, rsp.bresp)
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    req.araddr <= {idx, 2'b00};
    req.arvalid <= 1'b1;
    do tick(n); while (!rsp.arready);
    req.arvalid <= 1'b0;
    req.rready <= 1'b1;
    do tick(n); while (!rsp.rvalid);
    req.rready <= 1'b0;
    `CHK("rdata", e, rsp.rdata)
    `CHK("rresp", r, rsp.rresp)
  endtask
  // ====================
  // scenarios
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    porRst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 3; i++) rd(6'(IDX_PORT0_DIR + i), 32'h0, RESP_OKAY);
    rd(IDX_EDGE_SEL, 32'h0, RESP_OKAY);
    rd(IDX_CLK_CTRL, 32'h0, RESP_OKAY);
    `CHK("out1", OUT_RST, drv[1].out)
    `CHK("pullup2", OUT_RST, drv[2].pullupEn)
    ext[1] <= 8'h0f;
    wr(IDX_PORT1_DIR, 8'ha5);
    `CHK("out1 kept", 8'hff, drv[1].out)
    `CHK("oeN1", 8'h5a, drv[1].oeN)
    wr(IDX_PORT1_OUT, 8'h3c);
    repeat (4) @(posedge clk);
    rd(IDX_PORT1_IN, {24'h0, (8'ha5 & 8'h3c) | (8'h5a & 8'h0f)}, RESP_OKAY);
    wr(IDX_PORT2_IN, 8'hff);
    rd(IDX_PORT2_IN, 32'h0, RESP_OKAY);
    extEn[1] <= 8'h00;
    wr(IDX_PORT1_DIR, 8'h00);
    `CHK("pullup1", 8'h3c, drv[1].pullupEn)
    port3In <= 9'h1a5;
    repeat (4) @(posedge clk);
    rd(IDX_PORT3_IN, 32'h1a5, RESP_OKAY);
    rd(6'h3f, 32'h0, RESP_SLVERR);
    wr(6'h3f, 8'hff, RESP_SLVERR);
    wr(IDX_CLK_CTRL, 8'hff);
    rd(IDX_CLK_CTRL, 32'h3, RESP_OKAY);
    `CHK("sys sel", 1'b1, sysSel)
    `CHK("afe sel", 1'b1, afeSel)
    wr(IDX_EDGE_SEL, 8'h5a);
    wr(IDX_PORT0_DIR, 8'h81);
    `CHK("oeN0", 8'h7e, drv[0].oeN)
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(IDX_CLK_CTRL, 32'h3, RESP_OKAY);
    rd(IDX_EDGE_SEL, 32'h0, RESP_OKAY);
    rd(IDX_PORT0_DIR, 32'h0, RESP_OKAY);
    `CHK("oeN0 reset", 8'hff, drv[0].oeN)
    wr(IDX_CLK_CTRL, 8'h02);
    `CHK("sys sel off", 1'b0, sysSel)
    `CHK("afe sel on", 1'b1, afeSel)
    porRst <= 1'b1;
    @(posedge clk);
    porRst <= 1'b0;
    @(posedge clk);
    rd(IDX_CLK_CTRL, 32'h0, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'hff);
    for (int e = 0; e < 2; e++) begin
      wr(IDX_EDGE_SEL, {8{e[0]}});
      ext[0] <= {8{e[0]}};
      repeat (4) @(posedge clk);
      rd(IDX_IRQ_STATUS, 32'h0, RESP_OKAY);
      ext[0] <= {8{e[0]}} ^ 8'h81;
      repeat (4) @(posedge clk);
      rd(IDX_IRQ_STATUS, 32'h81, RESP_OKAY);
      `CHK("irq", 1'b1, irq)
      wr(IDX_IRQ_MASK, 8'h7e);
      `CHK("irq masked", 1'b0, irq)
      wr(IDX_IRQ_MASK, 8'hff);
      wr(IDX_IRQ_STATUS, 8'h01);
      rd(IDX_IRQ_STATUS, 32'h80, RESP_OKAY);
      wr(IDX_IRQ_STATUS, 8'h80);
      `CHK("irq cleared", 1'b0, irq)
    end
    conclude();
  end
endmodule

// ---- inc/gpe_pkg.sv ----
// shared constants and carrier types of the gpio edge / clock-select block
package gpe_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_PORT0_OUT = 6'h00;
  localparam logic [5:0] IDX_PORT1_OUT = 6'h01;
  localparam logic [5:0] IDX_PORT2_OUT = 6'h02;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h04;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h05;
  localparam logic [5:0] IDX_PORT1_IN = 6'h09;
  localparam logic [5:0] IDX_PORT2_IN = 6'h0a;
  localparam logic [5:0] IDX_PORT3_IN = 6'h0b;
  localparam logic [5:0] IDX_EDGE_SEL = 6'h0c;
  localparam logic [5:0] IDX_CLK_CTRL = 6'h0d;
  localparam logic [5:0] IDX_PORT0_DIR = 6'h10;
  localparam logic [5:0] IDX_PORT1_DIR = 6'h11;
  localparam logic [5:0] IDX_PORT2_DIR = 6'h12;

  // ==========================================================================
  // reset values and field positions
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] EDGE_SEL_RST = 8'h00;
  localparam logic [1:0] CLK_CTRL_RST = 2'h0;
  localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam int SYSCLK_FROM_PIN_SEL_BIT = 0;
  localparam int AFECLK_FROM_PIN_SEL_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // axi4-lite carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } gpe_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gpe_axil_rsp_t;

  // one 8-bit bidirectional port as seen at the pads
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oeN;
    logic [7:0] pullupEn;
  } gpe_port_drive_t;

  function automatic logic [7:0] gpe_byte_addr(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage
